//--- verilog/single_wire_bus_master_timing.sv
// single-wire bus master: reset/presence, bit slots and strong-pullup timing
// Notes on behaviour
// RL1: reset pulse drives the line low 626 us, or 63 us in overdrive.
// RL2: after reset release the line stays released 636 us, or 74 us overdrive.
// RL3: slaves answer reset with a presence pulse after a short wait.
// RL4: presence is sampled from 31 us (4 us overdrive, 38 us long-line).
// RL5: absence is concluded at 75 us (8 us overdrive) without a low seen.
// RL6: each bit slot lasts 86 us, or 15 us in overdrive.
// RL7: write one and read open hold the line low briefly, then release.
// RL8: write zero holds the line low 78 us, or 10 us in overdrive.
// RL9: slaves sample a written bit inside a fixed window of the slot.
// RL10: read bit is captured at 15 us (2 us overdrive, 25 us long-line).
// RL11: line-hold mode pulls the line low after 15 us in standard speed.
// RL12: after recovery delay read slots poll for high each tick; writes do not.
// RL13: after a byte's last bit the pullup stays on or lasts its active time.
// RL14: after presence wait 499/39 us, then enable pullup once the line is high.
// RL15: recovery pullup lasts 64/9 us after one, 8/1 us after zero, 1 us delay.
// RL16: presence pullup 8/1 us after 1 us delay; recovery pullup 10 us.
// RL17: pullup turns off 2 us before a reset and 1 us before a slot.
// RL18: before the first bit of a byte the pullup turn-off is 4 us.
// RL19: tick comes from a programmable divider; mode input picks the speed.
`timescale 1ns/100ps
module single_wire_bus_master_timing #(
  parameter int DIV_W = 8,
  parameter int CNT_W = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // configuration
  input wire logic [1:0] mode,
  input wire logic [DIV_W-1:0] div_ratio,
  input wire logic spu_en,
  input wire logic spu_hold,
  input wire logic line_hold_mode,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_reset,
  input wire logic cmd_read,
  input wire logic cmd_bit,
  input wire logic cmd_first,
  input wire logic cmd_last,
  // results
  output logic done,
  output logic rx_bit,
  output logic presence,
  output logic presence_done,
  // bus pins
  input wire logic bus_line_pin_in,
  output logic bus_line_pin_out,
  output logic bus_line_pin_oe,
  output logic strong_pullup_enable
);

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_OFF = 3'h1,
    S_RST_LOW = 3'h2,
    S_RST_HIGH = 3'h3,
    S_SLOT = 3'h4,
    S_REC = 3'h5
  } state_t;

  // refuse widths the counters cannot serve
  if (CNT_W < 12) begin : g_cnt_check
    $error("CNT_W must be at least 12");
  end
  if (DIV_W < 5) begin : g_div_check
    $error("DIV_W must be at least 5");
  end

  // time in ns to ticks for the selected speed
  function automatic logic [CNT_W-1:0] tsel(input logic [1:0] m, input int std_ns,
                                             input int od_ns, input int ll_ns);
    int r;
    if (m == sw_timing_pkg::MODE_OD) begin
      r = od_ns / sw_timing_pkg::TICK_OD_NS;
    end else if (m == sw_timing_pkg::MODE_LL) begin
      r = ll_ns / sw_timing_pkg::TICK_STD_NS;
    end else begin
      r = std_ns / sw_timing_pkg::TICK_STD_NS;
    end
    if (r < 1) begin
      r = 1;
    end
    return CNT_W'(r);
  endfunction

  state_t state_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  logic [DIV_W-1:0] div_limit;
  logic tick;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] op_cnt_reg;
  logic [CNT_W-1:0] off_len_reg;
  logic [CNT_W-1:0] spu_cnt_reg;
  logic [CNT_W-1:0] spu_len_reg;
  logic line_meta_reg;
  logic line_reg;
  logic op_reset_reg;
  logic op_read_reg;
  logic op_bit_reg;
  logic op_last_reg;
  logic seen_reg;
  logic fin_reg;
  logic cap_reg;
  logic poll_reg;
  logic poll_done_reg;
  logic pd_on_done_reg;
  logic spu_reg;
  logic drive_low_reg;
  logic rx_reg;
  logic done_reg;
  logic pdone_reg;

  // timing counts for the current speed
  logic [CNT_W-1:0] t_rst_low, t_rst_high, presence_sample_time, t_absent, t_slot, t_low, read_sample_time;
  logic [CNT_W-1:0] t_hold, t_pd_dly, t_pd_on, t_pdr_dly, t_pdr_on, t_rec_dly;
  logic [CNT_W-1:0] t_rec_on, t_off;
  logic go;
  logic restart;
  logic hold_low;
  logic low_phase;

  always_comb begin
    t_rst_low = tsel(mode, sw_timing_pkg::RESET_LOW_TIME_STD_NS,
                     sw_timing_pkg::RESET_LOW_TIME_OD_NS, sw_timing_pkg::RESET_LOW_TIME_STD_NS);
    t_rst_high = tsel(mode, sw_timing_pkg::RESET_HIGH_TIME_STD_NS,
                      sw_timing_pkg::RESET_HIGH_TIME_OD_NS, sw_timing_pkg::RESET_HIGH_TIME_STD_NS);
    presence_sample_time = tsel(mode, sw_timing_pkg::PRESENCE_SAMPLE_TIME_STD_NS,
                 sw_timing_pkg::PRESENCE_SAMPLE_TIME_OD_NS,
                 sw_timing_pkg::PRESENCE_SAMPLE_TIME_LL_NS);
    t_absent = tsel(mode, sw_timing_pkg::ABSENCE_WAIT_STD_NS,
                    sw_timing_pkg::ABSENCE_WAIT_OD_NS, sw_timing_pkg::ABSENCE_WAIT_STD_NS);
    t_slot = tsel(mode, sw_timing_pkg::SLOT_TIME_STD_NS,
                  sw_timing_pkg::SLOT_TIME_OD_NS, sw_timing_pkg::SLOT_TIME_STD_NS);
    if (op_bit_reg || op_read_reg) begin
      t_low = tsel(mode, sw_timing_pkg::ONE_LOW_TIME_STD_NS,
                   sw_timing_pkg::ONE_LOW_TIME_OD_NS, sw_timing_pkg::ONE_LOW_TIME_LL_NS);
    end else begin
      t_low = tsel(mode, sw_timing_pkg::ZERO_LOW_TIME_STD_NS,
                   sw_timing_pkg::ZERO_LOW_TIME_OD_NS, sw_timing_pkg::ZERO_LOW_TIME_STD_NS);
    end
    read_sample_time = tsel(mode, sw_timing_pkg::READ_SAMPLE_TIME_STD_NS,
                 sw_timing_pkg::READ_SAMPLE_TIME_OD_NS, sw_timing_pkg::READ_SAMPLE_TIME_LL_NS);
    t_hold = tsel(mode, sw_timing_pkg::LINE_HOLD_START_NS,
                  sw_timing_pkg::LINE_HOLD_START_NS, sw_timing_pkg::LINE_HOLD_START_NS);
    t_pd_dly = tsel(mode, sw_timing_pkg::SPU_PD_DELAY_NS,
                    sw_timing_pkg::SPU_PD_DELAY_NS, sw_timing_pkg::SPU_PD_DELAY_NS);
    t_pd_on = tsel(mode, sw_timing_pkg::SPU_PD_ON_STD_NS,
                   sw_timing_pkg::SPU_PD_ON_OD_NS, sw_timing_pkg::SPU_PD_ON_STD_NS);
    t_pdr_dly = tsel(mode, sw_timing_pkg::SPU_PDR_DELAY_STD_NS,
                     sw_timing_pkg::SPU_PDR_DELAY_OD_NS, sw_timing_pkg::SPU_PDR_DELAY_STD_NS);
    t_pdr_on = tsel(mode, sw_timing_pkg::SPU_PDR_ON_NS,
                    sw_timing_pkg::SPU_PDR_ON_NS, sw_timing_pkg::SPU_PDR_ON_NS);
    t_rec_dly = tsel(mode, sw_timing_pkg::SPU_REC_DELAY_NS,
                     sw_timing_pkg::SPU_REC_DELAY_NS, sw_timing_pkg::SPU_REC_DELAY_NS);
    if (op_bit_reg || op_read_reg) begin
      t_rec_on = tsel(mode, sw_timing_pkg::SPU_W1_ON_STD_NS,
                      sw_timing_pkg::SPU_W1_ON_OD_NS, sw_timing_pkg::SPU_W1_ON_STD_NS);
    end else begin
      t_rec_on = tsel(mode, sw_timing_pkg::SPU_W0_ON_STD_NS,
                      sw_timing_pkg::SPU_W0_ON_OD_NS, sw_timing_pkg::SPU_W0_ON_STD_NS);
    end
    if (cmd_reset) begin
      t_off = tsel(mode, sw_timing_pkg::SPU_OFF_RESET_NS,
                   sw_timing_pkg::SPU_OFF_RESET_NS, sw_timing_pkg::SPU_OFF_RESET_NS); // [RL17]
    end else if (cmd_first) begin
      t_off = tsel(mode, sw_timing_pkg::SPU_OFF_FIRST_NS,
                   sw_timing_pkg::SPU_OFF_FIRST_NS, sw_timing_pkg::SPU_OFF_FIRST_NS); // [RL18]
    end else begin
      t_off = tsel(mode, sw_timing_pkg::SPU_OFF_SLOT_NS,
                   sw_timing_pkg::SPU_OFF_SLOT_NS, sw_timing_pkg::SPU_OFF_SLOT_NS); // [RL17]
    end
  end

  // tick divider: div_ratio clocks per us, a twentieth of that in overdrive
  always_comb begin
    if (mode == sw_timing_pkg::MODE_OD) begin
      div_limit = DIV_W'(div_ratio / DIV_W'(sw_timing_pkg::OD_DIV_FACTOR)); // [RL19]
    end else begin
      div_limit = div_ratio; // [RL19]
    end
  end
  assign tick = (div_cnt_reg + DIV_W'(1) >= div_limit);

  // restart the divider when a command is accepted and when the turn-off ends, so those phases last whole ticks
  assign restart = go || (state_reg == S_OFF && cnt_reg >= off_len_reg);
  always_ff @(posedge sys_clk) begin
    if (!nrst || tick || restart) begin
      div_cnt_reg <= '0; // [RL19]
    end else begin
      div_cnt_reg <= div_cnt_reg + DIV_W'(1);
    end
  end

  // two-stage synchroniser on the bus line
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      line_meta_reg <= 1'b1;
      line_reg <= 1'b1;
    end else begin
      line_meta_reg <= bus_line_pin_in;
      line_reg <= line_meta_reg;
    end
  end

  assign go = cmd_valid && cmd_ready;
  assign cmd_ready = (state_reg == S_IDLE);

  // sequencer: state, tick counters and command latch
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_reg <= S_IDLE;
      cnt_reg <= '0;
      op_cnt_reg <= '0;
      off_len_reg <= '0;
      op_reset_reg <= 1'b0;
      op_read_reg <= 1'b0;
      op_bit_reg <= 1'b0;
      op_last_reg <= 1'b0;
    end else begin
      if (tick && op_cnt_reg != '1) begin
        op_cnt_reg <= op_cnt_reg + CNT_W'(1);
      end
      if (tick) begin
        cnt_reg <= cnt_reg + CNT_W'(1);
      end
      case (state_reg)
        S_IDLE: begin
          if (go) begin
            op_reset_reg <= cmd_reset;
            op_read_reg <= cmd_read;
            op_bit_reg <= cmd_bit;
            op_last_reg <= cmd_last;
            off_len_reg <= t_off;
            cnt_reg <= '0;
            op_cnt_reg <= '0;
            if (spu_reg) begin
              state_reg <= S_OFF;
            end else begin
              state_reg <= cmd_reset ? S_RST_LOW : S_SLOT;
            end
          end
        end
        S_OFF: begin
          if (cnt_reg >= off_len_reg) begin // [RL17] [RL18]
            cnt_reg <= '0;
            op_cnt_reg <= '0;
            state_reg <= op_reset_reg ? S_RST_LOW : S_SLOT;
          end
        end
        S_RST_LOW: begin
          if (cnt_reg >= t_rst_low) begin // [RL1]
            cnt_reg <= '0;
            state_reg <= S_RST_HIGH;
          end
        end
        S_RST_HIGH: begin
          if (cnt_reg >= t_rst_high) begin // [RL2]
            state_reg <= S_IDLE;
          end
        end
        S_SLOT: begin
          if (cnt_reg >= t_slot) begin // [RL6]
            state_reg <= (poll_reg || (spu_reg && !spu_hold)) ? S_REC : S_IDLE;
          end
        end
        S_REC: begin
          if (!poll_reg && !(spu_reg && !spu_hold)) begin
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // line drive: reset pulse, slot low phase and line-hold mode
  assign low_phase = (state_reg == S_RST_LOW) || (state_reg == S_SLOT && cnt_reg < t_low);
  assign hold_low = line_hold_mode && (mode == sw_timing_pkg::MODE_STD) &&
                    (state_reg == S_RST_LOW || state_reg == S_RST_HIGH ||
                     state_reg == S_SLOT) && (op_cnt_reg >= t_hold);
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      drive_low_reg <= 1'b0;
    end else begin
      drive_low_reg <= low_phase || hold_low; // [RL1] [RL7] [RL8] [RL11]
    end
  end

  // presence window and read capture
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      seen_reg <= 1'b0;
      fin_reg <= 1'b0;
      cap_reg <= 1'b0;
      rx_reg <= 1'b0;
      pdone_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      pdone_reg <= 1'b0;
      done_reg <= 1'b0;
      if (go) begin
        seen_reg <= 1'b0;
        fin_reg <= 1'b0;
        cap_reg <= 1'b0;
      end
      if (state_reg == S_RST_HIGH) begin
        if (cnt_reg >= presence_sample_time && cnt_reg <= t_absent && !line_reg && !fin_reg) begin
          seen_reg <= 1'b1; // [RL3] [RL4]
        end
        if (cnt_reg >= t_absent && !fin_reg) begin
          fin_reg <= 1'b1; // [RL5]
          pdone_reg <= 1'b1;
        end
        if (cnt_reg >= t_rst_high) begin
          done_reg <= 1'b1;
        end
      end
      if (state_reg == S_SLOT) begin
        if (cnt_reg >= read_sample_time && !cap_reg) begin
          cap_reg <= 1'b1;
          rx_reg <= line_reg; // [RL10] [RL9]
        end
        if (cnt_reg >= t_slot) begin
          done_reg <= 1'b1;
        end
      end
    end
  end

  // strong pullup: presence, presence recovery, bit recovery and turn-off
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      spu_reg <= 1'b0;
      spu_cnt_reg <= '0;
      spu_len_reg <= '0;
      poll_reg <= 1'b0;
      poll_done_reg <= 1'b0;
      pd_on_done_reg <= 1'b0;
    end else begin
      if (tick && spu_reg) begin
        spu_cnt_reg <= spu_cnt_reg + CNT_W'(1);
      end
      case (state_reg)
        S_IDLE: begin
          poll_done_reg <= 1'b0;
          pd_on_done_reg <= 1'b0;
          poll_reg <= 1'b0;
          if (go) begin
            spu_reg <= 1'b0; // [RL13] [RL17]
          end
        end
        S_RST_HIGH: begin
          if (spu_en && !pd_on_done_reg && !spu_reg && cnt_reg >= presence_sample_time + t_pd_dly) begin
            spu_reg <= 1'b1; // [RL16]
            spu_cnt_reg <= '0;
            spu_len_reg <= t_pd_on;
            pd_on_done_reg <= 1'b1;
          end else if (spu_en && !poll_done_reg && cnt_reg >= presence_sample_time + t_pdr_dly) begin
            if (tick && line_reg) begin
              spu_reg <= 1'b1; // [RL14] [RL16]
              spu_cnt_reg <= '0;
              spu_len_reg <= t_pdr_on;
              poll_done_reg <= 1'b1;
            end
          end else if (spu_reg && spu_cnt_reg >= spu_len_reg) begin
            spu_reg <= 1'b0;
          end
        end
        S_SLOT, S_REC: begin
          if (state_reg == S_SLOT && spu_en && op_last_reg && !poll_done_reg &&
              cnt_reg >= t_low + t_rec_dly) begin
            poll_reg <= 1'b1; // [RL15]
            poll_done_reg <= 1'b1;
          end
          if (poll_reg && (!op_read_reg || (tick && line_reg))) begin
            poll_reg <= 1'b0; // [RL12]
            spu_reg <= 1'b1;
            spu_cnt_reg <= '0;
            spu_len_reg <= t_rec_on; // [RL15]
          end else if (spu_reg && !spu_hold && spu_cnt_reg >= spu_len_reg) begin
            spu_reg <= 1'b0; // [RL13]
          end
        end
        default: spu_reg <= 1'b0;
      endcase
    end
  end

  // outputs
  assign bus_line_pin_out = 1'b0;
  assign bus_line_pin_oe = drive_low_reg;
  assign strong_pullup_enable = spu_reg;
  assign rx_bit = rx_reg;
  assign presence = seen_reg;
  assign presence_done = pdone_reg;
  assign done = done_reg;

endmodule

//--- verilog/sw_timing_pkg.sv
// timing constants and encodings for the single-wire bus master
package sw_timing_pkg;
  // speed modes
  typedef enum logic [1:0] {
    MODE_STD = 2'h0,
    MODE_OD = 2'h1,
    MODE_LL = 2'h2
  } speed_mode_t;

  // clock and tick periods
  localparam int SYS_CLK_NS = 10;
  localparam int TICK_STD_NS = 1000;
  localparam int TICK_OD_NS = 50;
  localparam int OD_DIV_FACTOR = TICK_STD_NS / TICK_OD_NS;
  localparam int DIV_DEFAULT = TICK_STD_NS / SYS_CLK_NS;

  // bus line timing in ns (standard, overdrive, long-line)
  localparam int RESET_LOW_TIME_STD_NS = 626000;
  localparam int RESET_LOW_TIME_OD_NS = 63000;
  localparam int RESET_HIGH_TIME_STD_NS = 636000;
  localparam int RESET_HIGH_TIME_OD_NS = 74000;
  localparam int PRESENCE_SAMPLE_TIME_STD_NS = 31000;
  localparam int PRESENCE_SAMPLE_TIME_OD_NS = 4000;
  localparam int PRESENCE_SAMPLE_TIME_LL_NS = 38000;
  localparam int ABSENCE_WAIT_STD_NS = 75000;
  localparam int ABSENCE_WAIT_OD_NS = 8000;
  localparam int SLOT_TIME_STD_NS = 86000;
  localparam int SLOT_TIME_OD_NS = 15000;
  localparam int ONE_LOW_TIME_STD_NS = 6000;
  localparam int ONE_LOW_TIME_OD_NS = 1000;
  localparam int ONE_LOW_TIME_LL_NS = 9000;
  localparam int ZERO_LOW_TIME_STD_NS = 78000;
  localparam int ZERO_LOW_TIME_OD_NS = 10000;
  localparam int READ_SAMPLE_TIME_STD_NS = 15000;
  localparam int READ_SAMPLE_TIME_OD_NS = 2000;
  localparam int READ_SAMPLE_TIME_LL_NS = 25000;
  localparam int LINE_HOLD_START_NS = 15000;

  // strong-pullup timing in ns (standard, overdrive)
  localparam int SPU_PD_ON_STD_NS = 8000;
  localparam int SPU_PD_ON_OD_NS = 1000;
  localparam int SPU_PD_DELAY_NS = 1000;
  localparam int SPU_PDR_ON_NS = 10000;
  localparam int SPU_PDR_DELAY_STD_NS = 499000;
  localparam int SPU_PDR_DELAY_OD_NS = 39000;
  localparam int SPU_W1_ON_STD_NS = 64000;
  localparam int SPU_W1_ON_OD_NS = 9000;
  localparam int SPU_W0_ON_STD_NS = 8000;
  localparam int SPU_W0_ON_OD_NS = 1000;
  localparam int SPU_REC_DELAY_NS = 1000;
  localparam int SPU_OFF_RESET_NS = 2000;
  localparam int SPU_OFF_SLOT_NS = 1000;
  localparam int SPU_OFF_FIRST_NS = 4000;
endpackage

//--- tb/sw_timing_props.sv
// concurrent checks on the ports of the single-wire bus master
`timescale 1ns/100ps
module sw_timing_props #(
  parameter int DIV_W = 8,
  parameter int CNT_W = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // configuration
  input wire logic [1:0] mode,
  input wire logic [DIV_W-1:0] div_ratio,
  input wire logic spu_en,
  input wire logic spu_hold,
  input wire logic line_hold_mode,
  // command
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_reset,
  input wire logic cmd_read,
  input wire logic cmd_bit,
  input wire logic cmd_first,
  input wire logic cmd_last,
  // results
  input wire logic done,
  input wire logic rx_bit,
  input wire logic presence,
  input wire logic presence_done,
  // bus pins
  input wire logic bus_line_pin_in,
  input wire logic bus_line_pin_out,
  input wire logic bus_line_pin_oe,
  input wire logic strong_pullup_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [31:0] oe_run;
  // length of the current low drive on the line
  always_ff @(posedge sys_clk) begin
    if (!nrst) oe_run <= 32'h0;
    else if (bus_line_pin_oe) oe_run <= oe_run + 32'h1;
    else oe_run <= 32'h0;
  end
  a_pin_out_low: assert property (bus_line_pin_out == 1'b0)
    else $error("line output data not low");
  a_ready_drops: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready stayed high after accept");
  a_done_single: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_absence_single: assert property (presence_done |=> !presence_done)
    else $error("presence done longer than one cycle");
  a_absence_busy: assert property (presence_done |-> !cmd_ready)
    else $error("presence done while idle");
  a_reset_quiet: assert property ($rose(nrst) |-> !bus_line_pin_oe && !done && cmd_ready)
    else $error("outputs not cleared by reset");
  a_idle_released: assert property (cmd_ready && !line_hold_mode |-> !bus_line_pin_oe)
    else $error("line pulled low while idle");
  a_pullup_vs_low: assert property (strong_pullup_enable |-> !bus_line_pin_oe)
    else $error("pullup on while line pulled low");
  // 0x272 ticks is the longest low drive, the reset pulse
  a_low_bounded: assert property ($fell(bus_line_pin_oe) && !line_hold_mode
    |-> oe_run <= 32'h272 * div_ratio + 32'h4)
    else $error("low drive too long");
  c_absence: cover property (presence_done);
endmodule

//--- tb/sw_slave_model.sv
// behavioural slave on the open-drain line: presence answer and read zero
`timescale 1ns/100ps
module sw_slave_model #(
  parameter int US_NS = 200
) (
  // line and controls
  input wire logic line,
  input wire logic od,
  input wire logic answer_en,
  input wire logic read_zero,
  output logic pull
);
  realtime t0;
  // react to each falling edge the master makes
  initial begin
    pull = 1'b0;
    forever begin
      @(negedge line);
      if (!pull) begin
        t0 = $realtime;
        if (read_zero) begin
          pull = 1'b1;
          #((od ? 4 : 30) * US_NS) pull = 1'b0;
        end else begin
          @(posedge line);
          if ($realtime - t0 > (od ? 40 : 400) * US_NS && answer_en) begin
            #((od ? 3 : 30) * US_NS) pull = 1'b1;
            #((od ? 12 : 100) * US_NS) pull = 1'b0;
          end
        end
      end
    end
  end
endmodule

//--- tb/tb.sv
// self-checking bench for the single-wire bus master
`timescale 1ns/100ps
module tb;
  localparam int DIV = 20;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [7:0] div_ratio = 8'h14;
  logic spu_en = 1'b0, spu_hold = 1'b0, line_hold_mode = 1'b0, cmd_valid = 1'b0;
  logic cmd_reset = 1'b0, cmd_read = 1'b0, cmd_bit = 1'b0, cmd_first = 1'b0, cmd_last = 1'b0;
  logic answer_en = 1'b1, read_zero = 1'b0, ended, pd_seen;
  logic cmd_ready, done, rx_bit, presence, presence_done, pin_out, oe, spu, pull;
  wire logic line = ~(oe | pull);
  wire logic od = (mode == sw_timing_pkg::MODE_OD);
  int bad_count = 0, cmp_count = 0, cyc_n = 0, low_c, tot_c, oe_c, spu_c;
  // clock and hang guard
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc_n++;
    if (cyc_n == 95000) begin
      bad_count++;
      test_done();
    end
  end
  single_wire_bus_master_timing single_wire_bus_master_timing_i (
    .sys_clk(sys_clk), .nrst(nrst), .mode(mode), .div_ratio(div_ratio), .spu_en(spu_en),
    .spu_hold(spu_hold), .line_hold_mode(line_hold_mode), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_reset(cmd_reset), .cmd_read(cmd_read), .cmd_bit(cmd_bit),
    .cmd_first(cmd_first), .cmd_last(cmd_last), .done(done), .rx_bit(rx_bit),
    .presence(presence), .presence_done(presence_done), .bus_line_pin_in(line),
    .bus_line_pin_out(pin_out), .bus_line_pin_oe(oe), .strong_pullup_enable(spu));
  sw_slave_model #(.US_NS(DIV * 10)) sw_slave_model_i (
    .line(line), .od(od), .answer_en(answer_en), .read_zero(read_zero), .pull(pull));
  // ns figure to clock cycles at the chosen divider
  function automatic int cyc(input int ns, input logic odm);
    if (odm) return ns / sw_timing_pkg::TICK_OD_NS * (DIV / sw_timing_pkg::OD_DIV_FACTOR);
    return ns / sw_timing_pkg::TICK_STD_NS * DIV;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %0d want %0d", $time, seen, exp);
    end
  endtask
  task automatic near(input int seen, input int exp, input int tol);
    check(seen >= exp - tol && seen <= exp + tol, 1'b1);
  endtask
  // one command, then measure the line, pullup and completion
  task automatic op(input logic rst, input logic rd, input logic b, input logic f, input logic l);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_reset <= rst;
    cmd_read <= rd;
    cmd_bit <= b;
    cmd_first <= f;
    cmd_last <= l;
    @(negedge sys_clk);
    while (!cmd_ready) @(negedge sys_clk);
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    {low_c, tot_c, oe_c, spu_c, ended, pd_seen} = '0;
    while (done !== 1'b1) begin
      @(negedge sys_clk);
      tot_c++;
      if (oe) begin
        oe_c++;
        if (!ended) low_c++;
      end else if (low_c > 0) ended = 1'b1;
      spu_c += int'(spu);
      pd_seen |= presence_done;
    end
    while (!cmd_ready) begin
      @(negedge sys_clk);
      spu_c += int'(spu);
    end
    // hand back on a rising edge so the next input change lands there
    @(posedge sys_clk);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    check({oe, spu, cmd_ready}, 3'h1);
    nrst <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      mode <= m[1:0];
      answer_en <= (m != 1);
      op(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      near(low_c, m == 1 ? cyc(sw_timing_pkg::RESET_LOW_TIME_OD_NS, 1'b1) :
        cyc(sw_timing_pkg::RESET_LOW_TIME_STD_NS, 1'b0), 3);
      near(tot_c, m == 1 ? cyc(sw_timing_pkg::RESET_LOW_TIME_OD_NS +
        sw_timing_pkg::RESET_HIGH_TIME_OD_NS, 1'b1) : cyc(sw_timing_pkg::RESET_LOW_TIME_STD_NS
        + sw_timing_pkg::RESET_HIGH_TIME_STD_NS, 1'b0), 4);
      check(presence, m != 1);
      check(pd_seen, 1'b1);
    end
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 4; k++) begin
        mode <= m[1:0];
        read_zero <= (k == 2);
        op(1'b0, k >= 2, k == 1, 1'b0, 1'b0);
        near(low_c, k == 0 ? cyc(m == 1 ? sw_timing_pkg::ZERO_LOW_TIME_OD_NS :
          sw_timing_pkg::ZERO_LOW_TIME_STD_NS, m == 1) : cyc(m == 1 ?
          sw_timing_pkg::ONE_LOW_TIME_OD_NS : (m == 2 ? sw_timing_pkg::ONE_LOW_TIME_LL_NS :
          sw_timing_pkg::ONE_LOW_TIME_STD_NS), m == 1), 3);
        near(tot_c, cyc(m == 1 ? sw_timing_pkg::SLOT_TIME_OD_NS :
          sw_timing_pkg::SLOT_TIME_STD_NS, m == 1), 4);
        if (k >= 2) check(rx_bit, k == 3);
      end
    end
    read_zero <= 1'b0;
    mode <= 2'h0;
    line_hold_mode <= 1'b1;
    op(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    near(oe_c, cyc(sw_timing_pkg::ONE_LOW_TIME_STD_NS + sw_timing_pkg::SLOT_TIME_STD_NS -
      sw_timing_pkg::LINE_HOLD_START_NS, 1'b0), 2 * DIV);
    line_hold_mode <= 1'b0;
    spu_en <= 1'b1;
    op(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    near(spu_c, cyc(sw_timing_pkg::SPU_W1_ON_STD_NS, 1'b0), DIV + 3);
    op(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    near(spu_c, cyc(sw_timing_pkg::SPU_W0_ON_STD_NS, 1'b0), DIV + 3);
    spu_hold <= 1'b1;
    op(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    repeat (300) @(negedge sys_clk);
    check(spu, 1'b1);
    // pullup is on here, so a first-bit slot waits for the long turn-off
    op(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    near(tot_c, cyc(sw_timing_pkg::SLOT_TIME_STD_NS + sw_timing_pkg::SPU_OFF_FIRST_NS,
      1'b0), 4);
    op(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    spu_hold <= 1'b0;
    op(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    near(tot_c, cyc(sw_timing_pkg::SLOT_TIME_STD_NS + sw_timing_pkg::SPU_OFF_SLOT_NS,
      1'b0), 4);
    check(spu, 1'b0);
    test_done();
  end
endmodule
bind single_wire_bus_master_timing sw_timing_props #(.DIV_W(DIV_W), .CNT_W(CNT_W)) props_i (
  .sys_clk(sys_clk), .nrst(nrst), .mode(mode), .div_ratio(div_ratio), .spu_en(spu_en),
  .spu_hold(spu_hold), .line_hold_mode(line_hold_mode), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_reset(cmd_reset), .cmd_read(cmd_read), .cmd_bit(cmd_bit),
  .cmd_first(cmd_first), .cmd_last(cmd_last), .done(done), .rx_bit(rx_bit),
  .presence(presence), .presence_done(presence_done), .bus_line_pin_in(bus_line_pin_in),
  .bus_line_pin_out(bus_line_pin_out), .bus_line_pin_oe(bus_line_pin_oe),
  .strong_pullup_enable(strong_pullup_enable));
